// File: hw/ssdt_pkg.sv
/*
 Package for the slot switching delay timing block: modes, reference-clock
 periods, slot counts, FIFO depth and reset values.
 Assumes one 20 MHz clock and eight reference-clock periods per slot.
*/
package ssdt_pkg;
    // ==========================================================
    // frame geometry
    localparam int SSDT_SLOTS = 32;
    localparam int SSDT_SLOT_W = 5;
    localparam int SSDT_RCL_W = 3;
    localparam logic [2:0] SSDT_RCL_LAST = 3'h7;
    // ==========================================================
    // access periods of the internal reference clock
    localparam logic [2:0] SSDT_RCL_P0 = 3'h0;
    localparam logic [2:0] SSDT_RCL_P1 = 3'h1;
    localparam logic [2:0] SSDT_RCL_P3 = 3'h3;
    localparam logic [2:0] SSDT_RCL_P4 = 3'h4;
    localparam logic [2:0] SSDT_RCL_P5 = 3'h5;
    localparam logic [2:0] SSDT_RCL_P6 = 3'h6;
    localparam logic [2:0] SSDT_RCL_P7 = 3'h7;
    // ==========================================================
    // shift field values that move the subscriber frame later
    localparam logic [2:0] SSDT_SHIFT_LATE0 = 3'h0;
    localparam logic [2:0] SSDT_SHIFT_LATE1 = 3'h1;
    // ==========================================================
    // read-ahead distances, trigger slots and offsets in slots, per mode
    localparam logic [4:0] SSDT_DN_AHEAD0 = 5'h03;
    localparam logic [4:0] SSDT_DN_AHEAD1 = 5'h03;
    localparam logic [4:0] SSDT_DN_AHEAD2 = 5'h03;
    localparam logic [4:0] SSDT_DN_TRIG0 = 5'h01;
    localparam logic [4:0] SSDT_DN_TRIG1 = 5'h03;
    localparam logic [4:0] SSDT_DN_TRIG2 = 5'h07;
    localparam logic [4:0] SSDT_UP_TRIG0 = 5'h00;
    localparam logic [4:0] SSDT_UP_TRIG1 = 5'h01;
    localparam logic [4:0] SSDT_UP_TRIG2 = 5'h03;
    localparam logic [4:0] SSDT_UP_OFS0 = 5'h04;
    localparam logic [4:0] SSDT_UP_OFS1 = 5'h09;
    localparam logic [4:0] SSDT_UP_OFS2 = 5'h13;
    // ==========================================================
    // monitor/feature handler
    localparam int SSDT_MF_DEPTH = 16;
    localparam int SSDT_MF_AW = 4;
    localparam logic [4:0] SSDT_MF_CNT_RST = 5'h00;
    localparam logic [7:0] SSDT_BYTE_RST = 8'h00;
    localparam logic [7:0] SSDT_MF_IDLE_BYTE = 8'hFF;

    typedef enum logic [1:0] {
        SSDT_MODE0 = 2'h0,
        SSDT_MODE1 = 2'h1,
        SSDT_MODE2 = 2'h3
    } ssdt_mode_t;

    // gray along idle -> wait -> send/receive -> done
    typedef enum logic [1:0] {
        SSDT_MF_IDLE = 2'h0,
        SSDT_MF_WAIT = 2'h1,
        SSDT_MF_XFER = 2'h3,
        SSDT_MF_DONE = 2'h2
    } ssdt_mf_state_t;
endpackage

// File: hw/ssdt_mf_if.sv
/*
 Interface between the switch core and the monitor/feature handler.
 Assumes both ends share the core clock.
*/
`timescale 1ns/1ps
interface ssdt_mf_if;
    logic slot_hit;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    modport core (output slot_hit, output rx_byte, input tx_byte);
    modport handler (input slot_hit, input rx_byte, output tx_byte);
endinterface

// File: hw/ssdt_mf_handler.sv
/*
 Monitor/feature handler: 16-byte bidirectional FIFO and a small
 microprogram that exchanges one byte per frame with one subscriber slot.
 Assumes the core pulses slot_hit once per frame at the selected slot.
*/
`timescale 1ns/1ps
module ssdt_mf_handler
    import ssdt_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control
    input wire logic i_hs_mode,
    input wire logic i_start,
    // controller side
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_tx_full,
    output logic o_rx_empty,
    output logic o_busy,
    // core side
    ssdt_mf_if.handler mf
);
    // ==========================================================
    // storage: one tx and one rx FIFO, flip-flops
    logic [7:0] tx_mem_q [SSDT_MF_DEPTH], tx_mem_d [SSDT_MF_DEPTH];
    logic [7:0] rx_mem_q [SSDT_MF_DEPTH], rx_mem_d [SSDT_MF_DEPTH];
    logic [SSDT_MF_AW-1:0] tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d;
    logic [SSDT_MF_AW-1:0] rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
    logic [4:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
    logic [7:0] tx_byte_q, tx_byte_d, rdata_q, rdata_d;
    ssdt_mf_state_t st_q, st_d;
    logic tx_pop, rx_push, tx_push, rx_pop;

    // ==========================================================
    // microprogram and FIFO control
    always_comb begin
        st_d = st_q;
        tx_mem_d = tx_mem_q;
        rx_mem_d = rx_mem_q;
        tx_wp_d = tx_wp_q;
        tx_rp_d = tx_rp_q;
        rx_wp_d = rx_wp_q;
        rx_rp_d = rx_rp_q;
        tx_byte_d = tx_byte_q;
        rdata_d = rdata_q;
        tx_push = i_wr && (tx_cnt_q != 5'(SSDT_MF_DEPTH));
        rx_pop = i_rd && (rx_cnt_q != SSDT_MF_CNT_RST);
        tx_pop = 1'b0;
        rx_push = 1'b0;
        case (st_q)
            SSDT_MF_IDLE: if (i_start) st_d = SSDT_MF_WAIT;
            SSDT_MF_WAIT: if (mf.slot_hit) st_d = SSDT_MF_XFER;
            SSDT_MF_XFER: begin
                // both modes drop the byte when rx is full; neither waits on room nor overwrites
                rx_push = (rx_cnt_q != 5'(SSDT_MF_DEPTH)) || !i_hs_mode;
                rx_push = rx_push && (rx_cnt_q != 5'(SSDT_MF_DEPTH));
                tx_pop = tx_cnt_q != SSDT_MF_CNT_RST;
                tx_byte_d = tx_pop ? tx_mem_q[tx_rp_q] : SSDT_MF_IDLE_BYTE;
                st_d = (tx_pop || i_hs_mode) ? SSDT_MF_WAIT : SSDT_MF_DONE;
                if (i_hs_mode && !tx_pop) st_d = SSDT_MF_DONE;
            end
            SSDT_MF_DONE: st_d = SSDT_MF_IDLE;
            default: st_d = SSDT_MF_IDLE;
        endcase
        if (tx_push) begin
            tx_mem_d[tx_wp_q] = i_wdata;
            tx_wp_d = tx_wp_q + 1'b1;
        end
        if (tx_pop) tx_rp_d = tx_rp_q + 1'b1;
        if (rx_push) begin
            rx_mem_d[rx_wp_q] = mf.rx_byte;
            rx_wp_d = rx_wp_q + 1'b1;
        end
        if (rx_pop) begin
            rdata_d = rx_mem_q[rx_rp_q];
            rx_rp_d = rx_rp_q + 1'b1;
        end
        tx_cnt_d = 5'(tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop});
        rx_cnt_d = 5'(rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop});
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= SSDT_MF_IDLE;
            for (int k = 0; k < SSDT_MF_DEPTH; k++) begin
                tx_mem_q[k] <= SSDT_BYTE_RST;
                rx_mem_q[k] <= SSDT_BYTE_RST;
            end
            tx_wp_q <= '0;
            tx_rp_q <= '0;
            rx_wp_q <= '0;
            rx_rp_q <= '0;
            tx_cnt_q <= SSDT_MF_CNT_RST;
            rx_cnt_q <= SSDT_MF_CNT_RST;
            tx_byte_q <= SSDT_MF_IDLE_BYTE;
            rdata_q <= SSDT_BYTE_RST;
        end else begin
            st_q <= st_d;
            tx_mem_q <= tx_mem_d;
            rx_mem_q <= rx_mem_d;
            tx_wp_q <= tx_wp_d;
            tx_rp_q <= tx_rp_d;
            rx_wp_q <= rx_wp_d;
            rx_rp_q <= rx_rp_d;
            tx_cnt_q <= tx_cnt_d;
            rx_cnt_q <= rx_cnt_d;
            tx_byte_q <= tx_byte_d;
            rdata_q <= rdata_d;
        end
    end

    assign mf.tx_byte = tx_byte_q;
    assign o_rdata = rdata_q;
    assign o_tx_full = tx_cnt_q == 5'(SSDT_MF_DEPTH);
    assign o_rx_empty = rx_cnt_q == SSDT_MF_CNT_RST;
    assign o_busy = st_q != SSDT_MF_IDLE;
endmodule

// File: hw/ssdt_switch.sv
/*
 Slot switch core: serial/parallel conversion on the PCM and subscriber
 ports, one-frame data buffers per direction, access in fixed reference-clock
 periods, frame-bit shift, preprocessed slots and the monitor/feature handler.
 Assumes both frames start together unless shifted, one bit per clock,
 eight clocks per slot (one reference-clock period per bit), 32 slots.
*/
`timescale 1ns/1ps
module ssdt_switch
    import ssdt_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // configuration
    input wire logic [1:0] i_pcm_mode,
    input wire logic [1:0] i_sub_mode,
    input wire logic [2:0] i_pcm_shift,
    input wire logic [2:0] i_subscriber_data_shift_field,
    input wire logic i_pcm_sync,
    // connection memories: source slot per output slot
    input wire logic [SSDT_SLOTS*SSDT_SLOT_W-1:0] i_dn_map,
    input wire logic [SSDT_SLOTS*SSDT_SLOT_W-1:0] i_up_map,
    input wire logic [SSDT_SLOTS-1:0] i_prep_mask,
    // serial ports
    input wire logic i_pcm_rxd,
    output logic o_pcm_txd,
    input wire logic i_first_subscriber_upstream_input,
    output logic o_subscriber_downstream_output,
    // preprocessed slot exchange
    input wire logic [7:0] i_prep_tx,
    output logic [7:0] o_prep_rx,
    output logic o_prep_valid,
    // monitor/feature handler
    input wire logic [SSDT_SLOT_W-1:0] i_mf_slot,
    input wire logic i_mf_hs_mode,
    input wire logic i_mf_start,
    input wire logic i_mf_wr,
    input wire logic [7:0] i_mf_wdata,
    input wire logic i_mf_rd,
    output logic [7:0] o_mf_rdata,
    output logic o_mf_tx_full,
    output logic o_mf_rx_empty,
    output logic o_mf_busy
);
    // ==========================================================
    // frame counters, one per port; shift moves the access points
    logic [7:0] pcm_pos_q, pcm_pos_d, sub_pos_q, sub_pos_d;
    logic [7:0] pcm_load, sub_load;
    always_comb begin
        pcm_load = {5'h00, i_pcm_shift};
        // shift 000/001 puts the subscriber frame later, others earlier
        if (i_subscriber_data_shift_field == SSDT_SHIFT_LATE0 ||
            i_subscriber_data_shift_field == SSDT_SHIFT_LATE1) begin
            sub_load = 8'(8'h00 - {7'h00, i_subscriber_data_shift_field} - 8'h01);
        end else begin
            sub_load = {5'h00, i_subscriber_data_shift_field};
        end
        // losing sync parks the PCM counter so the next sync re-aligns
        pcm_pos_d = i_pcm_sync ? 8'(pcm_pos_q + 8'h01) : pcm_load;
        sub_pos_d = 8'(sub_pos_q + 8'h01);
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pcm_pos_q <= 8'h00;
            sub_pos_q <= 8'h00;
        end else begin
            pcm_pos_q <= pcm_pos_d;
            sub_pos_q <= sub_pos_d;
        end
    end
    logic [SSDT_SLOT_W-1:0] pcm_slot, sub_slot;
    logic [SSDT_RCL_W-1:0] pcm_rcl, sub_rcl;
    logic [7:0] sub_at;
    assign pcm_slot = pcm_pos_q[7:3];
    assign pcm_rcl = pcm_pos_q[2:0];
    // subscriber shift is an offset on its access points
    assign sub_at = 8'(sub_pos_q + sub_load);
    assign sub_slot = sub_at[7:3];
    assign sub_rcl = sub_at[2:0];

    // ==========================================================
    // group geometry per mode
    logic [4:0] pcm_grp_mask, dn_trig, up_trig, up_ofs;
    always_comb begin
        case (i_pcm_mode)
            SSDT_MODE0: begin
                pcm_grp_mask = 5'h01;
                up_trig = SSDT_UP_TRIG0;
                up_ofs = SSDT_UP_OFS0;
            end
            SSDT_MODE1: begin
                pcm_grp_mask = 5'h03;
                up_trig = SSDT_UP_TRIG1;
                up_ofs = SSDT_UP_OFS1;
            end
            default: begin
                pcm_grp_mask = 5'h07;
                up_trig = SSDT_UP_TRIG2;
                up_ofs = SSDT_UP_OFS2;
            end
        endcase
        case (i_sub_mode)
            SSDT_MODE0: dn_trig = SSDT_DN_TRIG0;
            SSDT_MODE1: dn_trig = SSDT_DN_TRIG1;
            default: dn_trig = SSDT_DN_TRIG2;
        endcase
    end

    // ==========================================================
    // serial to parallel on both inputs
    logic [7:0] pcm_sr_q, pcm_sr_d, sub_sr_q, sub_sr_d;
    logic [7:0] pcm_word_q, pcm_word_d, sub_word_q, sub_word_d;
    logic [7:0] sub_prev_q, sub_prev_d;
    logic [SSDT_SLOT_W-1:0] pcm_wslot_q, pcm_wslot_d, sub_wslot_q, sub_wslot_d;
    always_comb begin
        pcm_sr_d = {pcm_sr_q[6:0], i_pcm_rxd};
        sub_sr_d = {sub_sr_q[6:0], i_first_subscriber_upstream_input};
        pcm_word_d = pcm_word_q;
        sub_word_d = sub_word_q;
        sub_prev_d = sub_prev_q;
        pcm_wslot_d = pcm_wslot_q;
        sub_wslot_d = sub_wslot_q;
        if (pcm_rcl == SSDT_RCL_LAST) begin
            pcm_word_d = pcm_sr_d;
            pcm_wslot_d = pcm_slot;
        end
        if (sub_rcl == SSDT_RCL_LAST) begin
            sub_prev_d = sub_word_q;
            sub_word_d = sub_sr_d;
            sub_wslot_d = sub_slot;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pcm_sr_q <= SSDT_BYTE_RST;
            sub_sr_q <= SSDT_BYTE_RST;
            pcm_word_q <= SSDT_BYTE_RST;
            sub_word_q <= SSDT_BYTE_RST;
            sub_prev_q <= SSDT_BYTE_RST;
            pcm_wslot_q <= '0;
            sub_wslot_q <= '0;
        end else begin
            pcm_sr_q <= pcm_sr_d;
            sub_sr_q <= sub_sr_d;
            pcm_word_q <= pcm_word_d;
            sub_word_q <= sub_word_d;
            sub_prev_q <= sub_prev_d;
            pcm_wslot_q <= pcm_wslot_d;
            sub_wslot_q <= sub_wslot_d;
        end
    end

    // ==========================================================
    // access windows
    logic pcm_grp_start, dn_wr_en, sub_even, up_wr_en;
    logic dn_rd_en, up_rd_en, up_blk_start;
    assign pcm_grp_start = (pcm_slot & pcm_grp_mask) == 5'h00;
    // the group-start period is skipped for internal latency
    assign dn_wr_en = (pcm_rcl == SSDT_RCL_P0 || pcm_rcl == SSDT_RCL_P4 ||
                       pcm_rcl == SSDT_RCL_P7) &&
                      !(pcm_grp_start && pcm_rcl == SSDT_RCL_P0);
    assign sub_even = !sub_slot[0];
    assign up_wr_en = sub_even &&
                      (sub_rcl == SSDT_RCL_P1 || sub_rcl == SSDT_RCL_P3);
    // every odd slot closes a pair in all modes
    assign dn_rd_en = (sub_slot[0] == dn_trig[0]) &&
                      (sub_rcl == SSDT_RCL_P5 || sub_rcl == SSDT_RCL_P6);
    assign up_blk_start = ((pcm_slot & pcm_grp_mask) == 5'((up_trig + 5'h01) & pcm_grp_mask));
    assign up_rd_en = ((pcm_slot & pcm_grp_mask) == up_trig) &&
                      (pcm_rcl == SSDT_RCL_P0 || pcm_rcl == SSDT_RCL_P4 ||
                       pcm_rcl == SSDT_RCL_P7) &&
                      !(up_blk_start && pcm_rcl == SSDT_RCL_P0);

    // ==========================================================
    // one-frame data buffers, one per direction
    logic [7:0] dn_mem_q [SSDT_SLOTS], dn_mem_d [SSDT_SLOTS];
    logic [7:0] up_mem_q [SSDT_SLOTS], up_mem_d [SSDT_SLOTS];
    logic dn_pend_q, dn_pend_d;
    generate
        for (genvar g = 0; g < SSDT_SLOTS; g++) begin : g_mem
            // one word per slot, so a late read returns last frame data
            always_comb begin
                dn_mem_d[g] = dn_mem_q[g];
                up_mem_d[g] = up_mem_q[g];
                if (dn_pend_q && dn_wr_en && pcm_wslot_q == SSDT_SLOT_W'(g))
                    dn_mem_d[g] = pcm_word_q;
                // period 1 takes the even word of the pair, period 3 the odd one
                if (up_wr_en && sub_rcl == SSDT_RCL_P1 && sub_wslot_q == SSDT_SLOT_W'(g + 1))
                    up_mem_d[g] = sub_prev_q;
                if (up_wr_en && sub_rcl == SSDT_RCL_P3 && sub_wslot_q == SSDT_SLOT_W'(g))
                    up_mem_d[g] = sub_word_q;
            end
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    dn_mem_q[g] <= SSDT_BYTE_RST;
                    up_mem_q[g] <= SSDT_BYTE_RST;
                end else begin
                    dn_mem_q[g] <= dn_mem_d[g];
                    up_mem_q[g] <= up_mem_d[g];
                end
            end
        end
    endgenerate
    always_comb begin
        dn_pend_d = dn_pend_q;
        if (pcm_rcl == SSDT_RCL_LAST) dn_pend_d = 1'b1;
        else if (dn_pend_q && dn_wr_en) dn_pend_d = 1'b0;
    end

    // ==========================================================
    // buffer reads: two fetches per window, staged per output slot
    logic [7:0] dn_out_q [SSDT_SLOTS], dn_out_d [SSDT_SLOTS];
    logic [7:0] up_out_q [SSDT_SLOTS], up_out_d [SSDT_SLOTS];
    logic [SSDT_SLOT_W-1:0] dn_tgt, up_tgt;
    logic [SSDT_SLOT_W-1:0] up_base, up_half, up_idx;
    logic step_dn, step_up;
    always_comb begin
        step_dn = sub_rcl == SSDT_RCL_P6;
        step_up = pcm_rcl == SSDT_RCL_P7;
        // even slot on the first step, odd on the second
        dn_tgt = SSDT_SLOT_W'(sub_slot + SSDT_DN_AHEAD0 + {4'h0, step_dn});
        up_base = SSDT_SLOT_W'((pcm_slot & ~pcm_grp_mask) + up_ofs - up_trig);
        up_half = 5'((pcm_grp_mask + 5'h01) >> 1);
        up_tgt = SSDT_SLOT_W'(up_base + (step_up ? up_half : 5'h00));
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dn_pend_q <= 1'b0;
            for (int k = 0; k < SSDT_SLOTS; k++) begin
                dn_out_q[k] <= SSDT_BYTE_RST;
                up_out_q[k] <= SSDT_BYTE_RST;
            end
        end else begin
            dn_pend_q <= dn_pend_d;
            dn_out_q <= dn_out_d;
            up_out_q <= up_out_d;
        end
    end
    always_comb begin
        dn_out_d = dn_out_q;
        up_out_d = up_out_q;
        up_idx = up_tgt;
        if (dn_rd_en && sub_rcl != SSDT_RCL_P5 || dn_rd_en && !step_dn)
            dn_out_d[dn_tgt] = dn_mem_q[i_dn_map[dn_tgt*SSDT_SLOT_W +: SSDT_SLOT_W]];
        // a half block is one to four slots, four lanes cover every mode
        for (int h = 0; h < 4; h++) begin
            up_idx = SSDT_SLOT_W'(up_tgt + 5'(h));
            if (up_rd_en && (pcm_rcl == SSDT_RCL_P4 || step_up) && 5'(h) < up_half)
                up_out_d[up_idx] = up_mem_q[i_up_map[up_idx*SSDT_SLOT_W +: SSDT_SLOT_W]];
        end
    end

    // ==========================================================
    // parallel to serial, preprocessed slots and handler hook
    logic [7:0] pcm_tsr_q, pcm_tsr_d, sub_tsr_q, sub_tsr_d;
    logic [7:0] prep_rx_q, prep_rx_d;
    logic prep_valid_q, prep_valid_d;
    ssdt_mf_if mf_bus ();
    assign mf_bus.rx_byte = sub_word_q;
    // handler serves only its one selected slot
    assign mf_bus.slot_hit = (sub_rcl == SSDT_RCL_P0) && (sub_wslot_q == i_mf_slot);
    always_comb begin
        pcm_tsr_d = {pcm_tsr_q[6:0], 1'b0};
        sub_tsr_d = {sub_tsr_q[6:0], 1'b0};
        prep_rx_d = prep_rx_q;
        prep_valid_d = 1'b0;
        if (pcm_rcl == SSDT_RCL_LAST)
            pcm_tsr_d = up_out_q[5'(pcm_slot + 5'h01)];
        if (sub_rcl == SSDT_RCL_LAST) begin
            sub_tsr_d = dn_out_q[5'(sub_slot + 5'h01)];
            if (i_prep_mask[5'(sub_slot + 5'h01)]) sub_tsr_d = i_prep_tx;
            if (5'(sub_slot + 5'h01) == i_mf_slot) sub_tsr_d = mf_bus.tx_byte;
        end
        if (sub_rcl == SSDT_RCL_P0 && i_prep_mask[sub_wslot_q]) begin
            prep_rx_d = sub_word_q;
            prep_valid_d = 1'b1;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pcm_tsr_q <= SSDT_BYTE_RST;
            sub_tsr_q <= SSDT_BYTE_RST;
            prep_rx_q <= SSDT_BYTE_RST;
            prep_valid_q <= 1'b0;
        end else begin
            pcm_tsr_q <= pcm_tsr_d;
            sub_tsr_q <= sub_tsr_d;
            prep_rx_q <= prep_rx_d;
            prep_valid_q <= prep_valid_d;
        end
    end
    assign o_pcm_txd = pcm_tsr_q[7];
    assign o_subscriber_downstream_output = sub_tsr_q[7];
    assign o_prep_rx = prep_rx_q;
    assign o_prep_valid = prep_valid_q;

    ssdt_mf_handler u_mf (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_hs_mode(i_mf_hs_mode),
        .i_start(i_mf_start),
        .i_wr(i_mf_wr),
        .i_wdata(i_mf_wdata),
        .i_rd(i_mf_rd),
        .o_rdata(o_mf_rdata),
        .o_tx_full(o_mf_tx_full),
        .o_rx_empty(o_mf_rx_empty),
        .o_busy(o_mf_busy),
        .mf(mf_bus.handler)
    );
endmodule

// File: sim/ssdt_asserts.sv
/* checker on the switch ports: handler FIFO flags and prep pulse
 assumes one clock, reset active high */
`timescale 1ns/1ps
module ssdt_asserts (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // handler and prep ports
    input wire logic i_mf_wr,
    input wire logic i_mf_rd,
    input wire logic i_mf_start,
    input wire logic [7:0] o_mf_rdata,
    input wire logic o_mf_tx_full,
    input wire logic o_mf_rx_empty,
    input wire logic o_mf_busy,
    input wire logic o_prep_valid
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ==========================================================
    // assertions
    a_prep_pulse: assert property (o_prep_valid |=> !o_prep_valid)
        else $error("prep valid too long");
    a_full_hold: assert property (o_mf_tx_full && !o_mf_busy |=> o_mf_tx_full)
        else $error("full dropped while idle");
    a_full_cause: assert property ($rose(o_mf_tx_full) |-> $past(i_mf_wr))
        else $error("full without write");
    a_fill_step: assert property (!o_mf_tx_full && !i_mf_wr |=> !o_mf_tx_full)
        else $error("full rose alone");
    a_empty_hold: assert property (o_mf_rx_empty && !o_mf_busy |=> o_mf_rx_empty)
        else $error("rx filled while idle");
    a_empty_data: assert property (o_mf_rx_empty && i_mf_rd && !o_mf_busy
        |=> $stable(o_mf_rdata))
        else $error("refused read changed data");
    a_busy_cause: assert property ($rose(o_mf_busy)
        |-> $past(i_mf_start) || $past(i_mf_start, 2))
        else $error("busy without start");
    a_empty_cause: assert property ($fell(o_mf_rx_empty) |-> $past(o_mf_busy))
        else $error("rx byte outside exchange");
    c_full: cover property ($rose(o_mf_tx_full));
    c_busy: cover property ($rose(o_mf_busy));
    c_prep: cover property (o_prep_valid);
endmodule
bind ssdt_switch ssdt_asserts i_ssdt_asserts (.i_clk(i_clk), .i_rst(i_rst),
    .i_mf_wr(i_mf_wr), .i_mf_rd(i_mf_rd), .i_mf_start(i_mf_start),
    .o_mf_rdata(o_mf_rdata), .o_mf_tx_full(o_mf_tx_full),
    .o_mf_rx_empty(o_mf_rx_empty), .o_mf_busy(o_mf_busy), .o_prep_valid(o_prep_valid));

// File: sim/ssdt_serial_src.sv
/* far-side serial sources: PCM highway and first upstream input
 assumes one bit per clock, MSB first, frame starts at reset release */
`timescale 1ns/1ps
module ssdt_serial_src (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // byte sent in every slot
    input wire logic [7:0] i_pcm_byte,
    input wire logic [7:0] i_sub_byte,
    // serial lines
    output logic o_pcm_rxd,
    output logic o_sub_rxd
);
    logic [2:0] bit_q;
    // same byte in every slot: a wideband channel sees equal delay
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bit_q <= 3'h0;
            o_pcm_rxd <= 1'b0;
            o_sub_rxd <= 1'b0;
        end else begin
            bit_q <= bit_q + 3'h1;
            o_pcm_rxd <= i_pcm_byte[3'h7 - bit_q];
            o_sub_rxd <= i_sub_byte[3'h7 - bit_q];
        end
    end
endmodule

// File: sim/ssdt_switch_tb.sv
/* self-checking bench for ssdt_switch
 assumes the checker bind and the serial source model */
`timescale 1ns/1ps
module ssdt_switch_tb;
    import ssdt_pkg::*;
    logic clk = 1'b0, rst = 1'b1, sync = 1'b1, mf_hs = 1'b0;
    logic mf_start = 1'b0, mf_wr = 1'b0, mf_rd = 1'b0;
    logic [1:0] pm = 2'h0, sm = 2'h0;
    logic [2:0] psh = 3'h0, ssh = 3'h0;
    logic [159:0] dmap = '0, umap = '0;
    logic [31:0] mask = 32'h0, seed = 32'h19;
    logic [7:0] ptx = 8'h00, wdat = 8'h00, pbyte = 8'h00, sbyte = 8'h00, rdat, prx;
    logic [4:0] mslot = 5'h00;
    logic prxd, srxd, ptxd, stxd, full, empty, busy;
    logic [10:0] exp_q[$];
    int bad_count = 0, cmp_count = 0;
    ssdt_mode_t modes[3] = '{SSDT_MODE0, SSDT_MODE1, SSDT_MODE2};
    always #25 clk = ~clk;
    ssdt_serial_src i_ssdt_serial_src (.i_clk(clk), .i_rst(rst), .i_pcm_byte(pbyte),
        .i_sub_byte(sbyte), .o_pcm_rxd(prxd), .o_sub_rxd(srxd));
    ssdt_switch i_ssdt_switch (.i_clk(clk), .i_rst(rst), .i_pcm_mode(pm), .i_sub_mode(sm),
        .i_pcm_shift(psh), .i_subscriber_data_shift_field(ssh), .i_pcm_sync(sync),
        .i_dn_map(dmap), .i_up_map(umap), .i_prep_mask(mask), .i_pcm_rxd(prxd),
        .o_pcm_txd(ptxd), .i_first_subscriber_upstream_input(srxd),
        .o_subscriber_downstream_output(stxd), .i_prep_tx(ptx), .o_prep_rx(prx),
        .o_prep_valid(), .i_mf_slot(mslot), .i_mf_hs_mode(mf_hs), .i_mf_start(mf_start),
        .i_mf_wr(mf_wr), .i_mf_wdata(wdat), .i_mf_rd(mf_rd), .o_mf_rdata(rdat),
        .o_mf_tx_full(full), .o_mf_rx_empty(empty), .o_mf_busy(busy));
    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // serial capture has no frame marker, so any rotation of the byte passes
    function automatic bit rot_ok(input logic [7:0] s, input logic [7:0] e);
        logic [15:0] d;
        d = {e, e};
        rot_ok = 1'b0;
        for (int r = 0; r < 8; r++) if (s === d[15-r -: 8]) rot_ok = 1'b1;
    endfunction
    task automatic chk(input logic [10:0] e);
        exp_q.push_back(e);
        wait (exp_q.size() == 0);
        @(posedge clk);
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================================
    // monitor: bits 10:8 pick the output, flags exact, bytes up to rotation
    initial begin
        logic [10:0] e;
        logic [7:0] s;
        forever begin
            wait (exp_q.size() != 0);
            e = exp_q[0];
            s = 8'h00;
            @(negedge clk);
            case (e[10:8])
                3'h2: s = {7'h00, empty};
                3'h3: s = {7'h00, full};
                3'h4: s = rdat;
                3'h5: s = {7'h00, busy};
                3'h6: s = prx;
                default: for (int b = 0; b < 8; b++) begin
                    s = {s[6:0], e[8] ? ptxd : stxd};
                    @(negedge clk);
                end
            endcase
            void'(exp_q.pop_front());
            cmp_count++;
            if (!(e[10:8] inside {3'h2, 3'h3, 3'h5} ? s === e[7:0] : rot_ok(s, e[7:0]))) begin
                bad_count++;
                $display("[FAIL] sel %h exp %h got %h", e[10:8], e[7:0], s);
            end
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
    // ==========================================================
    // stimulus
    initial begin
        logic [31:0] r;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int m = 0; m < 5; m++) begin
            r = rnd();
            pm <= modes[m % 3];
            sm <= modes[(m + 1) % 3];
            pbyte <= r[7:0];
            sbyte <= r[15:8];
            ptx <= r[7:0];
            mask <= (m == 3) ? 32'hFFFFFFFF : 32'h0;
            for (int k = 0; k < 32; k++) begin
                dmap[5*k +: 5] <= r[20:16] ^ 5'(k);
                umap[5*k +: 5] <= r[25:21] ^ 5'(k);
            end
            if (m == 4) begin
                psh <= 3'h3;
                ssh <= 3'h5;
                sync <= 1'b0;
                repeat (4) @(posedge clk);
                sync <= 1'b1;
            end
            repeat (800) @(posedge clk);
            chk({3'h0, r[7:0]});
            chk({(m == 3) ? 3'h6 : 3'h1, r[15:8]});
        end
        mf_wr <= 1'b1;
        for (int i = 0; i < 15; i++) begin
            r = rnd();
            wdat <= r[7:0];
            @(posedge clk);
        end
        mf_wr <= 1'b0;
        chk(11'h300);
        mf_wr <= 1'b1;
        @(posedge clk);
        mf_wr <= 1'b0;
        chk(11'h301);
        mf_rd <= 1'b1;
        @(posedge clk);
        mf_rd <= 1'b0;
        chk(11'h201);
        mslot <= 5'h02;
        mf_hs <= 1'b1;
        mf_start <= 1'b1;
        @(posedge clk);
        mf_start <= 1'b0;
        chk(11'h501);
        repeat (4600) @(posedge clk);
        chk(11'h300);
        chk(11'h500);
        chk(11'h200);
        mf_rd <= 1'b1;
        @(posedge clk);
        mf_rd <= 1'b0;
        chk({3'h4, sbyte});
        end_of_test();
    end
endmodule
